//--- rtl/tsp_packetizer.sv
// serial character packetizer with apb registers and driver control
//
// Local design decisions: the APB register port and the register addresses.
`timescale 1ns/100ps
`include "tsp_map.svh"

module tsp_packetizer #(
	parameter int FIFO_DEPTH = 8,
	parameter int TICK_CYCLES = `TSP_TICK_CYCLES
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// received characters from the serial receiver
	input wire logic rx_valid,
	input wire tsp_pkg::tsp_char_t rx_data,
	output logic rx_ready,
	// outgoing print messages to the router
	output logic msg_valid,
	output logic msg_end,
	output tsp_pkg::tsp_char_t msg_data,
	output logic [7:0] msg_len,
	output logic [31:0] msg_route,
	input wire logic msg_ready,
	// route update from router write messages
	input wire logic route_wr_valid,
	input wire logic [31:0] route_wr_data,
	// line control
	input wire logic cts,
	input wire logic tx_busy,
	output logic tx_drv_en,
	output logic rx_en,
	output logic rts
);
	import tsp_pkg::*;

	localparam int PS_W = $clog2(TICK_CYCLES + 1);

	tsp_state_t state;
	tsp_state_t next_state;
	logic share_mode;
	tsp_drv_mode_t drv_mode;
	logic [7:0] size_lim;
	logic [7:0] gap_lim;
	logic [31:0] route;
	logic [7:0] count;
	logic [7:0] next_count;
	logic close_pend;
	logic [PS_W-1:0] prescale;
	logic [7:0] gap_ticks;
	logic [15:0] pkt_cnt;
	logic f_valid;
	tsp_char_t f_data;
	logic f_full;
	logic f_ready;

	// character fifo between receiver and assembly
	// a character offered while the receiver is muted is taken and lost
	tsp_fifo #(
		.WIDTH(8),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.pclk(pclk),
		.presetn(presetn),
		.in_valid(rx_valid & rx_en),
		.in_data(rx_data),
		.in_ready(rx_ready),
		.out_valid(f_valid),
		.out_data(f_data),
		.out_ready(f_ready),
		.full(f_full)
	);

	// apb decode; access phase ends with a registered pready
	// an unmapped address answers with pslverr and reads as zero
	wire acc = psel & penable & ~pready;
	wire wr_now = psel & penable & pready & pwrite;
	wire hit_ctrl = paddr == `TSP_OFS_CTRL;
	wire hit_limit = paddr == `TSP_OFS_LIMIT;
	wire hit_route = paddr == `TSP_OFS_ROUTE;
	wire hit_status = paddr == `TSP_OFS_STATUS;
	wire hit_pktcnt = paddr == `TSP_OFS_PKTCNT;
	wire hit_any = hit_ctrl | hit_limit | hit_route | hit_status | hit_pktcnt;

	// read mux
	wire [31:0] rd_ctrl = {29'h0, drv_mode, share_mode};
	wire [31:0] rd_limit = {16'h0, gap_lim, size_lim};
	wire [31:0] rd_status = {17'h0, tx_drv_en, rx_en, f_full, state, count};
	wire [31:0] rd_mux = hit_ctrl ? rd_ctrl :
		hit_limit ? rd_limit :
		hit_route ? route :
		hit_status ? rd_status :
		hit_pktcnt ? {16'h0, pkt_cnt} : 32'h0;

	// assembly decode
	// a character is pulled only while no beat is waiting for the router
	assign f_ready = (state == S_IDLE) | (state == S_OPEN);
	wire take = f_valid & f_ready;
	wire is_cr = f_data == `TSP_CHAR_CR;
	wire [7:0] cnt_inc = count + 8'h01;
	wire hit_size = (size_lim != 8'h00) & (cnt_inc >= size_lim);
	wire gap_out = (state == S_OPEN) & (gap_lim != 8'h00) &
		(gap_ticks > gap_lim);
	wire beat_done = msg_valid & msg_ready;
	wire tick = prescale == PS_W'(TICK_CYCLES - 1);
	wire timer_run = (state == S_OPEN) & ~take;

	// line driver decode
	wire follow_cts = (drv_mode == DRV_CTS_GATED_DRIVER) |
		(drv_mode == DRV_TWO_WIRE);
	wire mute_on_tx = (drv_mode == DRV_ECHO_SUPPRESS_HALF) |
		(drv_mode == DRV_TWO_WIRE);

	// apb handshake and read data
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0;
		end
		else
		begin
			pready <= acc;
			pslverr <= acc & ~hit_any;
			prdata <= (acc & ~pwrite) ? rd_mux : 32'h0;
		end
	end

	// configuration registers
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			share_mode <= 1'b0;
			drv_mode <= DRV_ALWAYS_ON_FULL_DUPLEX;
			size_lim <= `TSP_SIZE_RESET;
			gap_lim <= `TSP_GAP_RESET;
		end
		else if (wr_now && hit_ctrl)
		begin
			share_mode <= pwdata[`TSP_CTRL_SHARE_BIT];
			drv_mode <= tsp_drv_mode_t'(
				pwdata[`TSP_CTRL_DRV_MSB:`TSP_CTRL_DRV_LSB]);
		end
		else if (wr_now && hit_limit)
		begin
			size_lim <= pwdata[`TSP_LIM_SIZE_MSB:`TSP_LIM_SIZE_LSB];
			gap_lim <= pwdata[`TSP_LIM_GAP_MSB:`TSP_LIM_GAP_LSB];
		end
	end

	// target route: software write has priority over router update
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			route <= `TSP_ROUTE_RESET;
		else if (wr_now && hit_route)
			route <= pwdata;
		else if (route_wr_valid)
			route <= route_wr_data;
	end

	// assembly state machine
	always_comb
	begin
		next_state = state;
		case (state)
			S_IDLE, S_OPEN:
			begin
				if (take)
					next_state = S_DATA;
				else if (gap_out)
					next_state = S_END;
			end
			S_DATA:
			begin
				if (beat_done)
					next_state = close_pend ? S_END : S_OPEN;
			end
			S_END:
			begin
				if (beat_done)
					next_state = S_IDLE;
			end
			default:
				next_state = S_IDLE;
		endcase
	end

	// character count of the open packet
	always_comb
	begin
		next_count = count;
		if (take)
			next_count = cnt_inc;
		else if (state == S_END && beat_done)
			next_count = 8'h00;
	end

	// state, count and close decision
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state <= S_IDLE;
			count <= 8'h00;
			close_pend <= 1'b0;
		end
		else
		begin
			state <= next_state;
			count <= next_count;
			if (take)
				close_pend <= is_cr | hit_size;
		end
	end

	// gap timer, restarted by every character and every close
	// gap_ticks saturates so a long silence never wraps below the limit
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prescale <= '0;
			gap_ticks <= 8'h00;
		end
		else if (!timer_run)
		begin
			prescale <= '0;
			gap_ticks <= 8'h00;
		end
		else if (tick)
		begin
			prescale <= '0;
			if (gap_ticks != 8'hff)
				gap_ticks <= gap_ticks + 8'h01;
		end
		else
			prescale <= prescale + 1'b1;
	end

	// message beats to the router
	// msg_valid follows next_state, so a beat stands until it is taken
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			msg_valid <= 1'b0;
			msg_end <= 1'b0;
			msg_data <= 8'h00;
			msg_len <= 8'h00;
			msg_route <= 32'h0;
		end
		else
		begin
			msg_valid <= (next_state == S_DATA) | (next_state == S_END);
			msg_end <= next_state == S_END;
			msg_len <= next_count;
			if (take)
				msg_data <= f_data;
			if (take && state == S_IDLE)
				msg_route <= route;
		end
	end

	// closed packet counter
	// wraps to zero after the largest count
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			pkt_cnt <= 16'h0000;
		else if (state == S_END && beat_done)
			pkt_cnt <= pkt_cnt + 16'h0001;
	end

	// line driver, receiver enable and rts
	// these lag cts and tx_busy by one clock
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			tx_drv_en <= 1'b0;
			rx_en <= 1'b0;
			rts <= 1'b0;
		end
		else
		begin
			tx_drv_en <= follow_cts ? cts : 1'b1;
			rx_en <= mute_on_tx ? ~tx_busy : 1'b1;
			rts <= share_mode ? 1'b1 : tx_busy;
		end
	end

endmodule : tsp_packetizer

//--- rtl/tsp_map.svh
// register offsets, field positions, reset values and timing counts
`ifndef TSP_MAP_SVH
`define TSP_MAP_SVH

// register byte offsets
`define TSP_OFS_CTRL 12'h000
`define TSP_OFS_LIMIT 12'h004
`define TSP_OFS_ROUTE 12'h008
`define TSP_OFS_STATUS 12'h00c
`define TSP_OFS_PKTCNT 12'h010

// ctrl fields
`define TSP_CTRL_SHARE_BIT 0
`define TSP_CTRL_DRV_LSB 1
`define TSP_CTRL_DRV_MSB 2
`define TSP_CTRL_RESET 32'h0000_0000

// limit fields
`define TSP_LIM_SIZE_LSB 0
`define TSP_LIM_SIZE_MSB 7
`define TSP_LIM_GAP_LSB 8
`define TSP_LIM_GAP_MSB 15
`define TSP_SIZE_RESET 8'h40
`define TSP_GAP_RESET 8'h02
`define TSP_ROUTE_RESET 32'h0000_0000

// status fields
`define TSP_STAT_COUNT_LSB 0
`define TSP_STAT_STATE_LSB 8
`define TSP_STAT_FULL_BIT 12
`define TSP_STAT_RXEN_BIT 13
`define TSP_STAT_TXEN_BIT 14

// character codes
`define TSP_CHAR_CR 8'h0d

// timing: one gap tick is a hundredth of a second
`define TSP_CLK_PERIOD_NS 25
`define TSP_TICK_NS 10000000
`define TSP_TICK_CYCLES (`TSP_TICK_NS / `TSP_CLK_PERIOD_NS)

`endif

//--- rtl/tsp_pkg.sv
// types shared by the packetizer files
package tsp_pkg;

	// packet assembly states, one-hot
	typedef enum logic [3:0] {
		S_IDLE = 4'b0001,
		S_OPEN = 4'b0010,
		S_DATA = 4'b0100,
		S_END = 4'b1000
	} tsp_state_t;

	// line driver modes
	typedef enum logic [1:0] {
		DRV_ALWAYS_ON_FULL_DUPLEX = 2'h0,
		DRV_CTS_GATED_DRIVER = 2'h1,
		DRV_ECHO_SUPPRESS_HALF = 2'h2,
		DRV_TWO_WIRE = 2'h3
	} tsp_drv_mode_t;

	typedef logic [7:0] tsp_char_t;

endpackage : tsp_pkg

//--- rtl/tsp_fifo.sv
// character fifo with registered read stage
`timescale 1ns/100ps

module tsp_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// filling side
	input wire logic in_valid,
	input wire logic [WIDTH-1:0] in_data,
	output logic in_ready,
	// draining side
	output logic out_valid,
	output logic [WIDTH-1:0] out_data,
	input wire logic out_ready,
	// state
	output logic full
);

	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr;
	logic [AW-1:0] rd_ptr;
	logic [AW:0] cnt;
	logic [AW:0] next_cnt;

	// push when room, pop into the output stage when it is free
	wire push = in_valid & in_ready;
	wire pop = (cnt != '0) & (~out_valid | out_ready);
	wire [AW-1:0] wr_inc = (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
	wire [AW-1:0] rd_inc = (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;

	always_comb
	begin
		next_cnt = cnt;
		if (push && !pop)
			next_cnt = cnt + 1'b1;
		else if (pop && !push)
			next_cnt = cnt - 1'b1;
	end

	// storage has no reset
	always_ff @(posedge pclk)
	begin
		if (push)
			mem[wr_ptr] <= in_data;
	end

	// pointers, level and registered flags
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			cnt <= '0;
			in_ready <= 1'b0;
			full <= 1'b0;
		end
		else
		begin
			if (push)
				wr_ptr <= wr_inc;
			if (pop)
				rd_ptr <= rd_inc;
			cnt <= next_cnt;
			in_ready <= next_cnt < (AW+1)'(DEPTH);
			full <= next_cnt == (AW+1)'(DEPTH);
		end
	end

	// output stage: read data come from a register
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			out_valid <= 1'b0;
			out_data <= '0;
		end
		else if (pop)
		begin
			out_valid <= 1'b1;
			out_data <= mem[rd_ptr];
		end
		else if (out_ready)
			out_valid <= 1'b0;
	end

endmodule : tsp_fifo

//--- tb/tsp_packetizer_assertions.sv
// port timing checker for the packetizer
`timescale 1ns/100ps

module tsp_packetizer_assertions (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave side
	input wire logic psel,
	input wire logic penable,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// message side
	input wire logic msg_valid,
	input wire logic msg_end,
	input wire logic [7:0] msg_len,
	input wire logic [31:0] msg_route,
	input wire logic msg_ready,
	// line control
	input wire logic cts,
	input wire logic tx_busy,
	input wire logic tx_drv_en,
	input wire logic rx_en
);
	import tsp_pkg::*;
	logic [7:0] beats;
	logic up;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// data beats taken in the open packet
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			beats <= 8'h00;
		else if (msg_valid && msg_ready)
			beats <= msg_end ? 8'h00 : beats + 8'h01;
	// high from the second edge after reset, when line outputs are valid
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			up <= 1'b0;
		else
			up <= 1'b1;
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("pready held more than one cycle");
	a_wait_state: assert property (psel && penable && !pready |=> pready)
		else $error("apb answer not after one wait state");
	a_err_ready: assert property (pslverr |-> pready)
		else $error("pslverr outside pready");
	a_rdata_quiet: assert property (!pready |-> prdata == 32'h0)
		else $error("prdata nonzero outside answer");
	a_beat_hold: assert property (msg_valid && !msg_ready |=> msg_valid &&
		$stable(msg_end) && $stable(msg_route))
		else $error("message beat changed before taken");
	a_len_count: assert property (msg_valid && msg_end |-> msg_len == beats)
		else $error("packet length differs from data beats");
	a_drv_cts: assert property (up && !tx_drv_en |-> !$past(cts))
		else $error("driver off while cts was active");
	a_rx_busy: assert property (up && !rx_en |-> $past(tx_busy))
		else $error("receiver off while not transmitting");
	c_end: cover property (msg_valid && msg_end && msg_ready);
	c_err: cover property (pslverr);
	c_rx_off: cover property (up && !rx_en);
endmodule : tsp_packetizer_assertions

//--- tb/tsp_serial_dev.sv
// serial ascii device model feeding received characters
`timescale 1ns/100ps

module tsp_serial_dev (
	// clock
	input wire logic pclk,
	// character handshake
	input wire logic rx_ready,
	output logic rx_valid,
	output tsp_pkg::tsp_char_t rx_data
);
	import tsp_pkg::*;
	// idle line at time zero
	initial
	begin
		rx_valid = 1'b0;
		rx_data = 8'h00;
	end
	// hold a character until taken, then scramble the released line
	task send(input tsp_char_t c);
		@(posedge pclk);
		rx_valid <= 1'b1;
		rx_data <= c;
		do
			@(posedge pclk);
		while (rx_ready !== 1'b1);
		rx_valid <= 1'b0;
		rx_data <= ~c;
	endtask : send
endmodule : tsp_serial_dev

//--- tb/tsp_packetizer_test.sv
// self-checking bench for the packetizer
`timescale 1ns/100ps

module tsp_packetizer_test;
	import tsp_pkg::*;
	localparam int TICK = 20;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, erv, mr_en;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, msg_route, route_wr_data, rdv, rt;
	logic rx_valid, rx_ready, msg_valid, msg_end, msg_ready, route_wr_valid;
	logic cts, tx_busy, tx_drv_en, rx_en, rts;
	tsp_char_t rx_data, msg_data;
	logic [7:0] msg_len;
	logic [31:0] plen[$], prt[$];
	tsp_char_t exq[$];
	int errors, tests_run, n, m;
	tsp_packetizer #(.TICK_CYCLES(TICK)) i_tsp_packetizer (.pclk(pclk),
		.presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .rx_valid(rx_valid), .rx_data(rx_data),
		.rx_ready(rx_ready), .msg_valid(msg_valid), .msg_end(msg_end),
		.msg_data(msg_data), .msg_len(msg_len), .msg_route(msg_route),
		.msg_ready(msg_ready), .route_wr_valid(route_wr_valid),
		.route_wr_data(route_wr_data), .cts(cts), .tx_busy(tx_busy),
		.tx_drv_en(tx_drv_en), .rx_en(rx_en), .rts(rts));
	tsp_serial_dev i_tsp_serial_dev (.pclk(pclk), .rx_ready(rx_ready),
		.rx_valid(rx_valid), .rx_data(rx_data));
	// clock
	initial
	begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end
	// router takes beats at random, checks data and logs closed packets
	always @(posedge pclk)
	begin
		msg_ready <= mr_en && ($urandom % 2);
		if (msg_valid && msg_ready && !msg_end)
			cmp(msg_data, exq.pop_front());
		if (msg_valid && msg_ready && msg_end)
		begin
			plen.push_back(msg_len);
			prt.push_back(msg_route);
		end
	end
	task automatic cmp(input logic [31:0] g, input logic [31:0] e);
		tests_run++;
		if (g !== e)
		begin
			errors++;
			$display("unexpected at %0t: got %h want %h", $time, g, e);
		end
	endtask : cmp
	// one apb transfer, answer kept in rdv and erv
	task acc(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		rdv = prdata;
		erv = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : acc
	// wait for the next closed packet and check it
	task chk(input logic [31:0] ln, input logic [31:0] r);
		for (int i = 0; i < 3000 && plen.size() == 0; i++)
			@(posedge pclk);
		cmp(plen.pop_front(), ln);
		cmp(prt.pop_front(), r);
	endtask : chk
	// one character, remembered for the data check
	task ch(input tsp_char_t c);
		exq.push_back(c);
		i_tsp_serial_dev.send(c);
	endtask : ch
	// k random letters, never a carriage return
	task snd(input int k);
		for (int i = 0; i < k; i++)
			ch(tsp_char_t'(8'h41 + $urandom % 26));
	endtask : snd
	// expected {rts, rx_en, tx_drv_en} for ctrl v
	function logic [31:0] drv(logic [2:0] v, logic c, logic b);
		return {29'h0, v[0] | b, ~(v[2] & b), ~v[1] | c};
	endfunction : drv
	task wrap_up;
		$display("errors %0d tests_run %0d", errors, tests_run);
		if (errors == 0 && tests_run > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : wrap_up
	// watchdog
	initial
	begin
		repeat (20000) @(posedge pclk);
		errors++;
		wrap_up;
	end
	// main sequence
	initial
	begin
		{psel, penable, pwrite, paddr, pwdata} = '0;
		{route_wr_valid, route_wr_data, cts, tx_busy, msg_ready} = '0;
		{errors, tests_run} = '0;
		mr_en = 1'b1;
		presetn = 1'b0;
		void'($urandom(32'h81e0ed47));
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		repeat (2) @(posedge pclk);
		acc(0, 12'h004, 0);
		cmp(rdv, 32'h0000_0240);
		acc(0, 12'h020, 0);
		cmp({rdv[31:1], erv}, 32'h1);
		rt = $urandom;
		acc(1, 12'h008, rt);
		acc(0, 12'h008, 0);
		cmp(rdv, rt);
		$display("registers done");
		snd(2);
		ch(8'h0d);
		chk(3, rt);
		acc(1, 12'h004, 3);
		snd(6);
		chk(3, rt);
		chk(3, rt);
		$display("terminator and size done");
		rt = $urandom;
		@(posedge pclk);
		route_wr_valid <= 1'b1;
		route_wr_data <= rt;
		@(posedge pclk);
		route_wr_valid <= 1'b0;
		acc(1, 12'h004, 1);
		snd(3);
		for (n = 0; n < 3; n++)
			chk(1, rt);
		$display("single character done");
		acc(1, 12'h004, 32'h200);
		for (n = 0; n < 3; n++)
		begin
			snd(1);
			repeat (30) @(posedge pclk);
		end
		chk(3, rt);
		$display("gap done");
		acc(1, 12'h004, 0);
		mr_en = 1'b0;
		fork
			snd(12);
		join_none
		for (n = 0; n < 500 && rx_ready === 1'b1; n++)
			@(posedge pclk);
		acc(0, 12'h00c, 0);
		cmp(rdv[12], 1);
		mr_en = 1'b1;
		wait fork;
		ch(8'h0d);
		chk(13, rt);
		$display("buffer done");
		for (m = 0; m < 32; m++)
		begin
			acc(1, 12'h000, m[2:0]);
			cts <= m[3];
			tx_busy <= m[4];
			repeat (2) @(posedge pclk);
			cmp({29'h0, rts, rx_en, tx_drv_en}, drv(m[2:0], m[3], m[4]));
		end
		$display("driver modes done");
		acc(0, 12'h010, 0);
		cmp(rdv, 32'h0000_0008);
		presetn <= 1'b0;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		repeat (2) @(posedge pclk);
		acc(0, 12'h010, 0);
		cmp(rdv, 32'h0000_0000);
		acc(0, 12'h004, 0);
		cmp(rdv, 32'h0000_0240);
		cmp({29'h0, rts, rx_en, tx_drv_en}, 32'h7);
		$display("reset done");
		wrap_up;
	end
endmodule : tsp_packetizer_test

bind tsp_packetizer tsp_packetizer_assertions i_tsp_packetizer_assertions (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.prdata(prdata), .pready(pready), .pslverr(pslverr),
	.msg_valid(msg_valid), .msg_end(msg_end), .msg_len(msg_len),
	.msg_route(msg_route), .msg_ready(msg_ready), .cts(cts),
	.tx_busy(tx_busy), .tx_drv_en(tx_drv_en), .rx_en(rx_en));
